// ===== test_uart_status_irq_dma_errors.sv
// Testbench for the serial status, interrupt and error offset logic.
// Assumes the far-end model and an 8-clock bit time.
`timescale 1ns/100ps
`default_nettype none
module test_uart_status_irq_dma_errors;
  import uart_serial_pkg::*;
  logic clock_i, srst_i, cyc, stb, we, ack, txd, rxd, cts_n, rts_n;
  logic pop, buf_b, irq_en, irq, avail, strobe;
  logic [31:0] adr, wdat, rdat, rd;
  logic [15:0] off;
  logic [1:0] load, rx_act, tx_act;
  rx_entry_t dma_data;
  int n_mismatch, n_checks;

  uart_serial_ctrl #(.DEPTH(4), .BIT_CYCLES(8)) uart_serial_ctrl_inst (
    .clock_i(clock_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd),
    .clear_to_send_n_i(cts_n), .txd_o(txd), .request_to_send_n_o(rts_n),
    .rx_dma_pop_i(pop), .rx_dma_buf_b_i(buf_b), .rx_dma_offset_i(off),
    .rx_dma_load_i(load), .rx_buffer_active_i(rx_act),
    .tx_buffer_active_i(tx_act), .rx_dma_avail_o(avail),
    .rx_dma_strobe_o(strobe), .rx_dma_data_o(dma_data),
    .serial_irq_enable_i(irq_en), .serial_irq_o(irq));

  uart_far_end #(.BITC(8)) uart_far_end_inst (
    .clock_i(clock_i), .txd_i(txd), .rxd_o(rxd));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clock_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 100) n_mismatch++;
  endtask

  task automatic rdc(input logic [31:0] a, e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wgot(input int k);
    for (int n = 0; n < 2000 && uart_far_end_inst.n_got < k; n++)
      @(posedge clock_i);
  endtask

  task automatic dpop(input logic [15:0] o);
    @(posedge clock_i);
    {pop, off} <= {1'b1, o};
    @(posedge clock_i);
    pop <= 1'b0;
    @(posedge clock_i);
    chk(strobe, 1'b1);
    repeat (2) @(posedge clock_i);
  endtask

  task report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    {srst_i, cyc, stb, we, adr, wdat, cts_n} = {1'b1, 67'h0, 1'b1};
    {pop, buf_b, off, load, rx_act, tx_act, irq_en} = 25'h0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge clock_i);
    chk(uart_serial_ctrl_inst.status_r, 32'h40);
    srst_i <= 1'b0;
    rdc(LINE_STATUS_ADDR, 32'h44);
    rdc(FRAME_CONFIG_ADDR, 32'h0);
    wb(1'b1, FRAME_CONFIG_ADDR, 32'hFF);
    rdc(FRAME_CONFIG_ADDR, 32'h7F);
    chk(rts_n, 1'b0);
    rdc(32'h4000_C8F0, 32'h0);
    // Seven data bits, odd parity, two stops, held off by CTS
    wb(1'b1, FRAME_CONFIG_ADDR, 32'h3C);
    wb(1'b1, DATA_ADDR, 32'h54);
    repeat (40) @(posedge clock_i);
    chk(txd, 1'b1);
    rdc(LINE_STATUS_ADDR, 32'h04);
    cts_n <= 1'b0;
    wgot(1);
    // Eighth sample lands on the odd parity bit
    chk(uart_far_end_inst.got, 8'h54);
    repeat (16) @(posedge clock_i);
    rdc(LINE_STATUS_ADDR, 32'h45);
    wb(1'b1, FRAME_CONFIG_ADDR, 32'h22);
    wb(1'b1, DATA_ADDR, 32'hA5);
    wgot(2);
    chk(uart_far_end_inst.got, 8'hA5);
    // Parity then framing error through the DMA path
    wb(1'b1, FRAME_CONFIG_ADDR, 32'h6A);
    wb(1'b1, IRQ_STATUS_ADDR, 32'h3FF);
    uart_far_end_inst.send(8'h3C, 1'b1, 1'b1, 1'b0);
    chk(avail, 1'b1);
    rdc(LINE_STATUS_ADDR, 32'h67);
    wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
    chk(rd & 32'h284, 32'h84);
    dpop(16'h0003);
    chk({22'h0, dma_data}, 32'h23C);
    rdc(RX_ERR_A_ADDR, 32'h1_0003);
    rdc(LINE_STATUS_ADDR, 32'h45);
    uart_far_end_inst.send(8'h5A, 1'b1, 1'b0, 1'b1);
    rdc(LINE_STATUS_ADDR, 32'h57);
    dpop(16'h0007);
    rdc(RX_ERR_A_ADDR, 32'h1_0003);
    wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
    chk(rd & 32'h180, 32'h180);
    wb(1'b1, DMA_CONTROL_ADDR, 32'h1);
    rdc(RX_ERR_A_ADDR, 32'h0);
    // Overrun with auto RTS into buffer B
    wb(1'b1, FRAME_CONFIG_ADDR, 32'h62);
    wb(1'b1, IRQ_STATUS_ADDR, 32'h3FF);
    wb(1'b1, IRQ_ENABLE_ADDR, 32'h200);
    {irq_en, buf_b, off} <= {2'b11, 16'h000A};
    for (int i = 0; i < 5; i++)
      uart_far_end_inst.send(8'h11 + i[7:0], 1'b0, 1'b0, 1'b0);
    chk(rts_n, 1'b1);
    rdc(LINE_STATUS_ADDR, 32'h4F);
    chk(irq, 1'b1);
    irq_en <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(irq, 1'b0);
    irq_en <= 1'b1;
    rdc(RX_ERR_B_ADDR, 32'h1_000E);
    rdc(DATA_ADDR, 32'h11);
    rdc(LINE_STATUS_ADDR, 32'h47);
    for (int i = 1; i < 4; i++)
      rdc(DATA_ADDR, 32'h11 + i);
    rdc(LINE_STATUS_ADDR, 32'h45);
    chk(rts_n, 1'b0);
    load <= 2'b10;
    @(posedge clock_i);
    load <= 2'b00;
    rdc(RX_ERR_B_ADDR, 32'h0);
    // Buffer-complete events, then level mode
    wb(1'b1, IRQ_STATUS_ADDR, 32'h3FF);
    {tx_act, rx_act} <= 4'hF;
    @(posedge clock_i);
    {tx_act, rx_act} <= 4'h0;
    repeat (3) @(posedge clock_i);
    wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
    chk(rd & 32'h78, 32'h78);
    wb(1'b1, IRQ_MODE_ADDR, 32'h1);
    wb(1'b1, IRQ_STATUS_ADDR, 32'h3FF);
    repeat (3) @(posedge clock_i);
    wb(1'b0, IRQ_STATUS_ADDR, 32'h0);
    chk(rd & 32'h3, 32'h3);
    report_and_stop;
  end
endmodule // test_uart_status_irq_dma_errors
`default_nettype wire

// ===== uart_far_end.sv
// Far-end serial device: sends frames on rxd, captures frames from txd.
// Assumes BITC clocks per bit, as set on the block under test.
`timescale 1ns/100ps
`default_nettype none
module uart_far_end #(
  parameter int BITC = 8
) (
  // Clock and serial lines
  input wire logic clock_i,
  input wire logic txd_i,
  output logic rxd_o
);
  logic [7:0] got;
  int n_got;

  initial begin
    rxd_o = 1'b1;
    got = 8'h00;
    n_got = 0;
  end

  task automatic bit_out(input logic b);
    rxd_o <= b;
    repeat (BITC) @(posedge clock_i);
  endtask

  // Start, LSB first, even parity, stop, then idle high
  task automatic send(input logic [7:0] d, input logic par, bad_par,
                      bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (par) bit_out(^d ^ bad_par);
    bit_out(~bad_stop);
    bit_out(1'b1);
  endtask

  // Always samples eight bit slots after the start bit
  always begin
    @(negedge txd_i);
    repeat (BITC + BITC / 2) @(posedge clock_i);
    for (int i = 0; i < 8; i++) begin
      got[i] = txd_i;
      repeat (BITC) @(posedge clock_i);
    end
    n_got++;
    wait (txd_i);
  end
endmodule // uart_far_end
`default_nettype wire

// ===== uart_serial_ctrl.sv
// Serial port with status, interrupt events and receive DMA error offsets.
// Assumes a classic Wishbone master and a receive DMA engine on clock_i.
// What this block does
// - DMA pop checks stored parity and framing flags
// - Record offset of first erroneous character per buffer
// - Overrun records offset four characters beyond
// - DMA reset bit, or reload of an inactive buffer, clears error record
// - Transmit idle event, edge or level mode
// - Transmit space event, edge or level mode
// - Receive valid event, edge or level mode
// - Buffer complete events on active flag falling
// - Separate parity, framing and overrun events
// - Interrupt needs event enable and top enable
// - Status bit 6: transmit FIFO and shifter empty
// - Status bit 5: head character parity error
// - Status bit 4: head character framing error
// - Status bit 3: overrun, cleared by data read
// - Status bit 2: transmit FIFO has room
// - Status bit 1: receive FIFO not empty
// - Status bit 0: clear-to-send logical state
// - Line status resets to 0x40
// - Configuration resets zero, fixed bit layout
// - Seven or eight data bits both directions
// - Flow control gates character start only
// - Auto RTS, with flow control also on, low while room for two
// - Four-entry transmit and receive FIFOs
`timescale 1ns/100ps
`default_nettype none

module uart_serial_ctrl #(
  parameter int DEPTH = 4,
  parameter int BIT_CYCLES = uart_serial_pkg::BIT_CYCLES_DEFAULT
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial pins
  input wire logic rxd_i,
  input wire logic clear_to_send_n_i,
  output logic txd_o,
  output logic request_to_send_n_o,
  // Receive DMA channel and transmit buffer flags
  input wire logic rx_dma_pop_i,
  input wire logic rx_dma_buf_b_i,
  input wire logic [uart_serial_pkg::OFFSET_W-1:0] rx_dma_offset_i,
  input wire logic [1:0] rx_dma_load_i,
  input wire logic [1:0] rx_buffer_active_i,
  input wire logic [1:0] tx_buffer_active_i,
  output logic rx_dma_avail_o,
  output logic rx_dma_strobe_o,
  output uart_serial_pkg::rx_entry_t rx_dma_data_o,
  // Interrupt
  input wire logic serial_irq_enable_i,
  output logic serial_irq_o
);
  import uart_serial_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] RTS_LIMIT = CW'(DEPTH - 2);
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic parity_of(input logic [7:0] d, input logic eight,
                                     input logic odd);
    parity_of = ^(eight ? d : {1'b0, d[6:0]}) ^ odd;
  endfunction

  frame_config_t cfg_r;
  line_status_t status_r;
  logic [IRQ_BITS-1:0] irq_status_r, irq_enable_r;
  logic irq_mode_r;
  logic [OFFSET_W:0] rx_err_r [2];
  logic rxd_meta_r, rxd_sync_r, cts_meta_r, cts_sync_r;
  logic [7:0] tx_mem [DEPTH];
  rx_entry_t rx_mem [DEPTH];
  logic [PW-1:0] tx_rd_r, tx_wr_r, rx_rd_r, rx_wr_r;
  logic [CW-1:0] tx_count_r, rx_count_r;
  ser_state_t tx_state_r, rx_state_r;
  logic [15:0] tx_tick_r, rx_tick_r;
  logic [2:0] tx_bit_r, rx_bit_r;
  logic [7:0] tx_shift_r, rx_shift_r;
  logic tx_stop2_r, rx_par_r;
  logic rx_push, rx_drop;
  rx_entry_t rx_new;
  logic prev_idle_r, prev_space_r, prev_valid_r;
  logic [1:0] prev_txact_r, prev_rxact_r;

  // Bus decode; a write or pop acts on the acknowledging edge
  logic bus_req, bus_wr, bus_rd, data_wr, data_rd, dma_pop, tx_pop;
  logic [1:0] dma_rst;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign bus_rd = bus_req & ~wb_we_i & wb_ack_o;
  assign data_wr = bus_wr & (wb_adr_i == DATA_ADDR) && tx_count_r != FULL;
  assign data_rd = bus_rd & (wb_adr_i == DATA_ADDR);
  assign dma_pop = rx_dma_pop_i & ~data_rd & (rx_count_r != '0);
  assign dma_rst = (bus_wr && wb_adr_i == DMA_CONTROL_ADDR) ?
                   {wb_dat_i[RX_DMA_RESET_B], wb_dat_i[RX_DMA_RESET_A]} : 2'b00;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req & ~wb_ack_o) begin
      case (wb_adr_i)
        LINE_STATUS_ADDR: wb_dat_o <= {25'h0, status_r};
        FRAME_CONFIG_ADDR: wb_dat_o <= {25'h0, cfg_r};
        DATA_ADDR: wb_dat_o <= {24'h0, rx_mem[rx_rd_r].data};
        IRQ_STATUS_ADDR: wb_dat_o <= {22'h0, irq_status_r};
        IRQ_ENABLE_ADDR: wb_dat_o <= {22'h0, irq_enable_r};
        IRQ_MODE_ADDR: wb_dat_o <= {31'h0, irq_mode_r};
        RX_ERR_A_ADDR: wb_dat_o <= {15'h0, rx_err_r[0]};
        RX_ERR_B_ADDR: wb_dat_o <= {15'h0, rx_err_r[1]};
        default: wb_dat_o <= '0;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_r <= FRAME_CONFIG_RESET;
      irq_enable_r <= '0;
      irq_mode_r <= 1'b0;
    end else if (bus_wr) begin
      case (wb_adr_i)
        FRAME_CONFIG_ADDR: cfg_r <= wb_dat_i[6:0];
        IRQ_ENABLE_ADDR: irq_enable_r <= wb_dat_i[IRQ_BITS-1:0];
        IRQ_MODE_ADDR: irq_mode_r <= wb_dat_i[0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      {rxd_meta_r, rxd_sync_r, cts_meta_r, cts_sync_r} <= 4'hF;
    end else begin
      rxd_meta_r <= rxd_i;
      rxd_sync_r <= rxd_meta_r;
      cts_meta_r <= clear_to_send_n_i;
      cts_sync_r <= cts_meta_r;
    end
  end

  // Transmit FIFO
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_wr_r <= '0;
      tx_rd_r <= '0;
      tx_count_r <= '0;
    end else begin
      if (data_wr) begin
        tx_mem[tx_wr_r] <= wb_dat_i[7:0];
        tx_wr_r <= ptr_inc(tx_wr_r);
      end
      if (tx_pop) begin
        tx_rd_r <= ptr_inc(tx_rd_r);
      end
      tx_count_r <= tx_count_r + CW'(data_wr) - CW'(tx_pop);
    end
  end

  // Transmitter; a frame starts only with CTS when flow is on
  assign tx_pop = (tx_state_r == SER_IDLE) && tx_count_r != '0 &&
                  (~cfg_r.flow_control_enable | ~cts_sync_r);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_state_r <= SER_IDLE;
      tx_tick_r <= '0;
      tx_bit_r <= '0;
      tx_shift_r <= '0;
      tx_stop2_r <= 1'b0;
      txd_o <= 1'b1;
    end else if (tx_state_r == SER_IDLE) begin
      txd_o <= 1'b1;
      if (tx_pop) begin
        tx_shift_r <= tx_mem[tx_rd_r];
        tx_tick_r <= '0;
        txd_o <= 1'b0;
        tx_state_r <= SER_START;
      end
    end else if (tx_tick_r != BIT_LAST) begin
      tx_tick_r <= tx_tick_r + 16'h0001;
    end else begin
      tx_tick_r <= '0;
      case (tx_state_r)
        SER_START: begin
          tx_state_r <= SER_DATA;
          tx_bit_r <= '0;
          txd_o <= tx_shift_r[0];
        end
        SER_DATA: begin
          if (tx_bit_r == 3'(cfg_r.eight_data_bits ? DATA_BITS_LONG - 1 :
                             DATA_BITS_SHORT - 1)) begin
            tx_state_r <= cfg_r.parity_enable ? SER_PARITY : SER_STOP;
            txd_o <= cfg_r.parity_enable ? parity_of(tx_shift_r,
                     cfg_r.eight_data_bits, cfg_r.odd_parity_select) : 1'b1;
            tx_stop2_r <= cfg_r.two_stop_select;
          end else begin
            tx_bit_r <= tx_bit_r + 3'h1;
            txd_o <= tx_shift_r[tx_bit_r + 3'h1];
          end
        end
        SER_PARITY: begin
          tx_state_r <= SER_STOP;
          txd_o <= 1'b1;
        end
        SER_STOP: begin
          tx_stop2_r <= 1'b0;
          if (!tx_stop2_r) begin
            tx_state_r <= SER_IDLE;
          end
        end
        default: tx_state_r <= SER_IDLE;
      endcase
    end
  end

  // Receiver, sampling each bit at its middle
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_state_r <= SER_IDLE;
      rx_tick_r <= '0;
      rx_bit_r <= '0;
      rx_shift_r <= '0;
      rx_par_r <= 1'b0;
      rx_push <= 1'b0;
      rx_new <= '0;
    end else begin
      rx_push <= 1'b0;
      if (rx_state_r == SER_IDLE) begin
        rx_tick_r <= '0;
        if (!rxd_sync_r) begin
          rx_state_r <= SER_START;
        end
      end else if (rx_state_r == SER_START ? rx_tick_r != HALF_LAST :
                   rx_tick_r != BIT_LAST) begin
        rx_tick_r <= rx_tick_r + 16'h0001;
      end else begin
        rx_tick_r <= '0;
        case (rx_state_r)
          SER_START: begin
            rx_state_r <= rxd_sync_r ? SER_IDLE : SER_DATA;
            rx_bit_r <= '0;
            rx_shift_r <= '0;
          end
          SER_DATA: begin
            rx_shift_r[rx_bit_r] <= rxd_sync_r;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'(cfg_r.eight_data_bits ? DATA_BITS_LONG - 1 :
                               DATA_BITS_SHORT - 1)) begin
              rx_state_r <= cfg_r.parity_enable ? SER_PARITY : SER_STOP;
            end
          end
          SER_PARITY: begin
            rx_par_r <= rxd_sync_r ^ parity_of(rx_shift_r,
                        cfg_r.eight_data_bits, cfg_r.odd_parity_select);
            rx_state_r <= SER_STOP;
          end
          SER_STOP: begin
            rx_push <= 1'b1;
            rx_new <= '{par_err: rx_par_r & cfg_r.parity_enable,
                        frm_err: ~rxd_sync_r, data: rx_shift_r};
            rx_par_r <= 1'b0;
            rx_state_r <= SER_IDLE;
          end
          default: rx_state_r <= SER_IDLE;
        endcase
      end
    end
  end

  // Receive FIFO; a character meeting a full FIFO is dropped unless a pop occurs in that cycle
  logic rx_pop;
  assign rx_pop = (data_rd && rx_count_r != '0) || dma_pop;
  assign rx_drop = rx_push && rx_count_r == FULL && !rx_pop;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_wr_r <= '0;
      rx_rd_r <= '0;
      rx_count_r <= '0;
    end else begin
      if (rx_push && !rx_drop) begin
        rx_mem[rx_wr_r] <= rx_new;
        rx_wr_r <= ptr_inc(rx_wr_r);
      end
      if (rx_pop) begin
        rx_rd_r <= ptr_inc(rx_rd_r);
      end
      rx_count_r <= rx_count_r + CW'(rx_push && !rx_drop) - CW'(rx_pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_dma_strobe_o <= 1'b0;
      rx_dma_data_o <= '0;
      rx_dma_avail_o <= 1'b0;
    end else begin
      rx_dma_strobe_o <= dma_pop;
      rx_dma_avail_o <= rx_count_r != '0;
      if (dma_pop) begin
        rx_dma_data_o <= rx_mem[rx_rd_r];
      end
    end
  end

  // Error offset records for buffers A and B; a new error in the clearing cycle wins
  logic [1:0] err_clr;
  assign err_clr = dma_rst | (rx_dma_load_i & ~rx_buffer_active_i);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rx_err_r[0] <= '0;
      rx_err_r[1] <= '0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (err_clr[b]) begin
          rx_err_r[b] <= '0;
        end
        if (int'(rx_dma_buf_b_i) == b &&
            (err_clr[b] || !rx_err_r[b][ERR_VALID_BIT])) begin
          if (dma_pop && (rx_mem[rx_rd_r].par_err ||
                          rx_mem[rx_rd_r].frm_err)) begin
            rx_err_r[b] <= {1'b1, rx_dma_offset_i};
          end else if (rx_drop) begin
            rx_err_r[b] <= {1'b1, rx_dma_offset_i + RX_OVF_LEAD};
          end
        end
      end
    end
  end

  // Line status, refreshed every cycle
  line_status_t status_nxt;
  always_comb begin
    status_nxt.tx_idle_flag = tx_count_r == '0 &&
                              tx_state_r == SER_IDLE;
    status_nxt.parity_error_flag = rx_count_r != '0 &&
                                   rx_mem[rx_rd_r].par_err;
    status_nxt.framing_error_flag = rx_count_r != '0 &&
                                    rx_mem[rx_rd_r].frm_err;
    status_nxt.rx_overrun_flag = rx_drop ||
      (status_r.rx_overrun_flag && !data_rd);
    status_nxt.tx_space_flag = tx_count_r != FULL;
    status_nxt.rx_valid_flag = rx_count_r != '0;
    status_nxt.clear_to_send_state = ~cts_sync_r;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_r <= LINE_STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Flow control output
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      request_to_send_n_o <= 1'b1;
    end else if (cfg_r.auto_rts_enable && cfg_r.flow_control_enable) begin
      request_to_send_n_o <= rx_count_r > RTS_LIMIT;
    end else begin
      request_to_send_n_o <= ~cfg_r.software_rts_level;
    end
  end

  // Interrupt events; a set in the clearing cycle wins
  logic [IRQ_BITS-1:0] irq_set, irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_TX_IDLE] = status_nxt.tx_idle_flag &
                           (irq_mode_r | ~prev_idle_r);
    irq_set[IRQ_TX_SPACE] = status_nxt.tx_space_flag &
                            (irq_mode_r | ~prev_space_r);
    irq_set[IRQ_RX_VALID] = status_nxt.rx_valid_flag &
                            (irq_mode_r | ~prev_valid_r);
    irq_set[IRQ_TX_DONE_A +: 2] = prev_txact_r &
                                  ~tx_buffer_active_i;
    irq_set[IRQ_RX_DONE_A +: 2] = prev_rxact_r &
                                  ~rx_buffer_active_i;
    irq_set[IRQ_PARITY] = rx_push & rx_new.par_err;
    irq_set[IRQ_FRAMING] = rx_push & rx_new.frm_err;
    irq_set[IRQ_OVERRUN] = rx_drop;
    irq_clr = (bus_wr && wb_adr_i == IRQ_STATUS_ADDR) ?
              wb_dat_i[IRQ_BITS-1:0] : '0;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      irq_status_r <= '0;
      prev_idle_r <= 1'b1;
      prev_space_r <= 1'b1;
      prev_valid_r <= 1'b0;
      prev_txact_r <= '0;
      prev_rxact_r <= '0;
      serial_irq_o <= 1'b0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
      prev_idle_r <= status_nxt.tx_idle_flag;
      prev_space_r <= status_nxt.tx_space_flag;
      prev_valid_r <= status_nxt.rx_valid_flag;
      prev_txact_r <= tx_buffer_active_i;
      prev_rxact_r <= rx_buffer_active_i;
      serial_irq_o <= serial_irq_enable_i &&
                      |(irq_status_r & irq_enable_r);
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  AST_TX_IDLE: assert property (
    $past(tx_count_r) == '0 && $past(tx_state_r) == SER_IDLE
    |-> status_r.tx_idle_flag) else $error("idle flag not set");
  AST_TX_SPACE: assert property (
    $past(tx_count_r) == FULL |-> !status_r.tx_space_flag)
    else $error("space flag set while full");
  AST_RX_VALID: assert property (
    rx_count_r != '0 |=> status_r.rx_valid_flag)
    else $error("valid flag missing");
  AST_CTS_STATE: assert property (
    $fell(cts_sync_r) |=> status_r.clear_to_send_state)
    else $error("cts state not asserted");
  AST_OVERRUN: assert property (
    rx_drop |=> status_r.rx_overrun_flag && irq_status_r[IRQ_OVERRUN])
    else $error("overrun not flagged");
  AST_FLOW_GATE: assert property (
    tx_state_r == SER_IDLE && cfg_r.flow_control_enable && cts_sync_r
    |=> tx_state_r == SER_IDLE) else $error("start without cts");
  AST_AUTO_RTS: assert property (
    cfg_r.auto_rts_enable && cfg_r.flow_control_enable &&
    rx_count_r >= FULL - 1'b1 |=> request_to_send_n_o)
    else $error("rts asserted without room");
  AST_OVF_OFFSET: assert property (
    rx_drop && rx_dma_buf_b_i && !rx_err_r[1][ERR_VALID_BIT] && !dma_pop
    |=> rx_err_r[1] == {1'b1, $past(rx_dma_offset_i) + RX_OVF_LEAD})
    else $error("overrun offset wrong");
  AST_RX_DONE: assert property (
    $fell(rx_buffer_active_i[0]) |=> irq_status_r[IRQ_RX_DONE_A])
    else $error("buffer complete not flagged");
  AST_IRQ_GATE: assert property (
    serial_irq_o |-> $past(serial_irq_enable_i))
    else $error("irq without top enable");
  AST_FULL_DROP: assert property (
    rx_drop |=> rx_count_r == FULL) else $error("full fifo disturbed");

  COV_OVERRUN: cover property (rx_drop);
  COV_DMA_ERR: cover property (dma_pop ##1 rx_err_r[0][ERR_VALID_BIT]);
  COV_TX_DONE: cover property (tx_state_r == SER_STOP ##1
                              tx_state_r == SER_IDLE);

endmodule // uart_serial_ctrl
`default_nettype wire

// ===== uart_serial_pkg.sv
// Shared constants and types for the serial port status and error logic.
// Assumes a 40 MHz system clock and a 32-bit classic Wishbone slave port.
package uart_serial_pkg;

  // Register byte addresses
  localparam logic [31:0] LINE_STATUS_ADDR = 32'h4000_C848;
  localparam logic [31:0] FRAME_CONFIG_ADDR = 32'h4000_C85C;
  localparam logic [31:0] DATA_ADDR = 32'h4000_C900;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'h4000_C904;
  localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h4000_C908;
  localparam logic [31:0] IRQ_MODE_ADDR = 32'h4000_C90C;
  localparam logic [31:0] DMA_CONTROL_ADDR = 32'h4000_C910;
  localparam logic [31:0] RX_ERR_A_ADDR = 32'h4000_C914;
  localparam logic [31:0] RX_ERR_B_ADDR = 32'h4000_C918;

  // Reset values
  localparam logic [6:0] LINE_STATUS_RESET = 7'h40;
  localparam logic [6:0] FRAME_CONFIG_RESET = 7'h00;

  // Interrupt status bit positions
  localparam int IRQ_TX_IDLE = 0;
  localparam int IRQ_TX_SPACE = 1;
  localparam int IRQ_RX_VALID = 2;
  localparam int IRQ_TX_DONE_A = 3;
  localparam int IRQ_RX_DONE_A = 5;
  localparam int IRQ_PARITY = 7;
  localparam int IRQ_FRAMING = 8;
  localparam int IRQ_OVERRUN = 9;
  localparam int IRQ_BITS = 10;

  // DMA control and error offset fields
  localparam int RX_DMA_RESET_A = 0;
  localparam int RX_DMA_RESET_B = 1;
  localparam int OFFSET_W = 16;
  localparam int ERR_VALID_BIT = 16;
  localparam logic [15:0] RX_OVF_LEAD = 16'h0004;

  // Bit timing
  localparam int CLOCK_HZ = 40_000_000;
  localparam int BAUD_DEFAULT = 115_200;
  localparam int BIT_CYCLES_DEFAULT = CLOCK_HZ / BAUD_DEFAULT;
  localparam int DATA_BITS_SHORT = 7;
  localparam int DATA_BITS_LONG = 8;

  typedef struct packed {
    logic tx_idle_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic rx_overrun_flag;
    logic tx_space_flag;
    logic rx_valid_flag;
    logic clear_to_send_state;
  } line_status_t;

  typedef struct packed {
    logic auto_rts_enable;
    logic flow_control_enable;
    logic odd_parity_select;
    logic parity_enable;
    logic two_stop_select;
    logic eight_data_bits;
    logic software_rts_level;
  } frame_config_t;

  typedef struct packed {
    logic par_err;
    logic frm_err;
    logic [7:0] data;
  } rx_entry_t;

  typedef enum logic [4:0] {
    SER_IDLE = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA = 5'b00100,
    SER_PARITY = 5'b01000,
    SER_STOP = 5'b10000
  } ser_state_t;

endpackage
